// File: rtl/frame_slot.v
// Holds one outgoing frame between the command logic and the CAN controller
// Assumes the controller takes the frame on txValid and txReady both high
`timescale 1ns/1ps

module frame_slot (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        loadValid,
    input  wire [28:0] loadId,
    input  wire [3:0]  loadDlc,
    input  wire [63:0] loadData,
    output wire        loadReady,
    output reg         txValid,
    output reg  [28:0] txId,
    output reg  [3:0]  txDlc,
    output reg  [63:0] txData,
    input  wire        txReady
);

    assign loadReady = !txValid;

    always @(posedge clk) begin
        if (!rst_n) begin
            txValid <= 1'b0;
            txId    <= 29'h0;
            txDlc   <= 4'h0;
            txData  <= 64'h0;
        end else if (loadValid && !txValid) begin
            txValid <= 1'b1;
            txId    <= loadId;
            txDlc   <= loadDlc;
            txData  <= loadData;
        end else if (txValid && txReady) begin
            txValid <= 1'b0;
        end
    end

endmodule

// File: rtl/pair_io_defs.vh
// Frame field layout, function codes and selector codes for the pair-connection node
// Included by the node logic; definitions only
`ifndef PAIR_IO_DEFS_VH
`define PAIR_IO_DEFS_VH

// 29-bit identifier: [28:24] reserved, [23] ack, [22:15] func, [14:8] node, [7:0] adv
`define ID_ACK_BIT      23
`define ID_FUNC_MSB     22
`define ID_FUNC_LSB     15
`define ID_NODE_MSB     14
`define ID_NODE_LSB     8
`define ID_ADV_MSB      7
`define ID_ADV_LSB      0

`define FUNC_SET_OUT    8'h10
`define FUNC_IO_TYPE    8'hF3
`define FUNC_CONFLICT   8'h61
`define FUNC_HEARTBEAT  8'h70

`define ADV_PAIR_SET    8'h01
`define ADV_IN_REPORT   8'h02
`define ADV_NONE        8'h00

`define SEL_PAIR_LOW    4'h8
`define SEL_500K_PAIR   4'hD

`define DLC_ONE         4'h1
`define DLC_IO_TYPE     4'h6
`define DLC_SET         4'h8

`endif

// File: rtl/pair_io_node.v
// Message-level logic of a digital I/O slave node with pair-connection mode
// Assumes a CAN controller that delivers received frames as one-cycle strobes
// and accepts frames through a valid/ready handshake; switches are raw pins
//
// Notes on behaviour
// (R1) Pair mode is on when the rate selector reads 8 to F on both partners.
// (R2) The input-side module of a pair carries an odd node number.
// (R3) An input module sends pair commands to its own number plus one, and an output module accepts them from its number minus one.
// (R4) Selector position D means 500 kbps together with pair mode.
// (R5) In pair mode the node goes operational on its own without a master command.
// (R6) An input channel going ON drives the same-index output channel ON at the partner.
// (R7) One input node may feed several output nodes and several input nodes may feed one output node.
// (R8) A master cannot tell apart the I/O types of nodes sharing one number.
// (R9) In pair mode no acknowledged reply is sent to an ID conflict check.
// (R10) In pair mode heartbeat supervision is off and heartbeat frames have no effect.
// (R11) In pair mode set and query commands from a master are still answered.
// (R12) An input change on the input side of a pair sends two frames, the first setting the partner outputs.
// (R13) The second frame reports the input status toward the master, master or not.
// (R14) An output-set command updates the outputs, then a reply with the output status is sent.
// (R15) The I/O type reply holds six counts: dig out, dig in, analog out, analog in, pwm, counter.
// (R16) The pair set frame uses function 10h, flag 1, and its reply sets ack with one byte.
// (R17) The input report uses the own node number, flag 2 and one status byte.
`timescale 1ns/1ps
`include "pair_io_defs.vh"

module pair_io_node #(
    parameter CHANNELS        = 8,
    parameter HB_TIMEOUT_CYC  = 32'h02FAF080
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [3:0]  rateSwitch,
    input  wire [6:0]  nodeSwitch,
    input  wire [7:0]  input_channels,
    output reg  [7:0]  outputChannels,
    output reg         pairMode,
    output reg         fastRate,
    output reg         operational,
    output reg         heartbeatLost,
    input  wire        rxStrobe,
    input  wire [28:0] rxId,
    input  wire        rxRtr,
    input  wire [3:0]  rxDlc,
    input  wire [63:0] rxData,
    output wire        txValid,
    output wire [28:0] txId,
    output wire [3:0]  txDlc,
    output wire [63:0] txData,
    input  wire        txReady
);

    // Type reply counts, one byte each; no analog, pulse or counter channels
    localparam [7:0] DIG_OUT_COUNT   = CHANNELS[7:0];
    localparam [7:0] DIG_IN_COUNT    = CHANNELS[7:0];
    localparam [7:0] analog_out_count = 8'h00;
    localparam [7:0] analog_in_count  = 8'h00;
    localparam [7:0] PWM_COUNT        = 8'h00;
    localparam [7:0] COUNTER_COUNT    = 8'h00;

    localparam [2:0] S_IDLE    = 3'h0;
    localparam [2:0] S_PAIRSET = 3'h1;
    localparam [2:0] S_REPORT  = 3'h2;
    localparam [2:0] S_OUTACK  = 3'h3;
    localparam [2:0] S_TYPEACK = 3'h4;
    localparam [2:0] S_CONFACK = 3'h5;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    reg [3:0] rateMeta;
    reg [3:0] rateSync;
    reg [6:0] nodeMeta;
    reg [6:0] nodeSync;
    reg [7:0] inMeta;
    reg [7:0] inSync;
    reg [7:0] inLast;

    always @(posedge clk) begin
        if (!rst_n) begin
            rateMeta <= 4'h0;
            rateSync <= 4'h0;
            nodeMeta <= 7'h00;
            nodeSync <= 7'h00;
            inMeta   <= 8'h00;
            inSync   <= 8'h00;
        end else begin
            rateMeta <= rateSwitch;
            rateSync <= rateMeta;
            nodeMeta <= nodeSwitch;
            nodeSync <= nodeMeta;
            inMeta   <= input_channels;
            inSync   <= inMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode; switch read once settled, held while running

    function [28:0] makeId;
        input       ack;
        input [7:0] func;
        input [6:0] node;
        input [7:0] adv;
        begin
            makeId = {5'h00, ack, func, node, adv};
        end
    endfunction

    function [7:0] funcOf;
        input [28:0] id;
        begin
            funcOf = id[`ID_FUNC_MSB:`ID_FUNC_LSB];
        end
    endfunction

    reg [1:0] settle;
    reg [6:0] nodeId;

    always @(posedge clk) begin
        if (!rst_n) begin
            settle      <= 2'h0;
            pairMode    <= 1'b0;
            fastRate    <= 1'b0;
            nodeId      <= 7'h00;
            operational <= 1'b0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end else if (!operational && pairMode) begin
            operational <= 1'b1; // R5
        end else if (!operational) begin
            pairMode <= (rateSync >= `SEL_PAIR_LOW); // R1
            fastRate <= (rateSync == `SEL_500K_PAIR); // R4
            nodeId   <= nodeSync;
            // Non-pair start waits for the master; modelled as the start command below
            if (rxStrobe && funcOf(rxId) == 8'h01)
                operational <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Heartbeat supervision, inert in pair mode

    // Flag holds at the limit until a heartbeat or pair mode clears it
    reg [31:0] hbCount;

    always @(posedge clk) begin
        if (!rst_n) begin
            hbCount       <= 32'h0;
            heartbeatLost <= 1'b0;
        end else if (pairMode || !operational) begin
            hbCount       <= 32'h0; // R10
            heartbeatLost <= 1'b0; // R10
        end else if (rxStrobe && funcOf(rxId) == `FUNC_HEARTBEAT) begin
            hbCount       <= 32'h0;
            heartbeatLost <= 1'b0;
        end else if (hbCount >= HB_TIMEOUT_CYC) begin
            heartbeatLost <= 1'b1;
        end else begin
            hbCount <= hbCount + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive decode

    wire [7:0] rxFunc  = funcOf(rxId);
    wire [6:0] rxNode  = rxId[`ID_NODE_MSB:`ID_NODE_LSB];
    wire [7:0] rxAdv   = rxId[`ID_ADV_MSB:`ID_ADV_LSB];
    wire       rxCmd   = rxStrobe && operational && !rxId[`ID_ACK_BIT];
    wire       toMe    = (rxNode == nodeId);
    // Several input nodes with one shared number may drive this node
    wire       fromPeer = pairMode && (rxAdv == `ADV_PAIR_SET)
                          && (rxNode == nodeId) && nodeId[0] == 1'b0; // R3 R7
    wire       setCmd  = rxCmd && (rxFunc == `FUNC_SET_OUT) && !rxRtr
                         && (toMe || fromPeer); // R11 R14
    wire       typeQry = rxCmd && toMe && (rxFunc == `FUNC_IO_TYPE) && rxRtr; // R11
    wire       confQry = rxCmd && toMe && (rxFunc == `FUNC_CONFLICT) && rxRtr;

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencing

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg         pending;
    reg  [7:0]  snapIn;
    reg         loadValid;
    reg  [28:0] loadId;
    reg  [3:0]  loadDlc;
    reg  [63:0] loadData;
    wire        loadReady;
    wire        inChange = operational && (inSync != inLast);
    // Odd number marks the input side of a pair
    wire        isInputSide = pairMode && nodeId[0];

    always @* begin
        next_state = state;
        loadValid  = 1'b0;
        loadId     = 29'h0;
        loadDlc    = 4'h0;
        loadData   = 64'h0;
        case (state)
            S_PAIRSET: begin
                loadValid = 1'b1;
                loadId    = makeId(1'b0, `FUNC_SET_OUT, nodeId + 7'h01, `ADV_PAIR_SET); // R3 R16
                loadDlc   = `DLC_SET;
                loadData  = {snapIn, 56'h0}; // R6 R12
                if (loadReady)
                    next_state = S_REPORT;
            end
            S_REPORT: begin
                loadValid = 1'b1;
                loadId    = makeId(1'b1, `FUNC_SET_OUT, nodeId, `ADV_IN_REPORT); // R13 R17
                loadDlc   = `DLC_ONE;
                loadData  = {snapIn, 56'h0};
                if (loadReady)
                    next_state = S_IDLE;
            end
            S_OUTACK: begin
                loadValid = 1'b1;
                loadId    = makeId(1'b1, `FUNC_SET_OUT, nodeId, `ADV_PAIR_SET); // R14 R16
                loadDlc   = `DLC_ONE;
                loadData  = {outputChannels, 56'h0};
                if (loadReady)
                    next_state = S_IDLE;
            end
            S_TYPEACK: begin
                loadValid = 1'b1;
                loadId    = makeId(1'b1, `FUNC_IO_TYPE, nodeId, `ADV_NONE);
                loadDlc   = `DLC_IO_TYPE;
                loadData  = {DIG_OUT_COUNT, DIG_IN_COUNT, analog_out_count,
                             analog_in_count, PWM_COUNT, COUNTER_COUNT, 16'h0}; // R15
                if (loadReady)
                    next_state = S_IDLE;
            end
            S_CONFACK: begin
                loadValid = 1'b1;
                loadId    = makeId(1'b1, `FUNC_CONFLICT, nodeId, `ADV_PAIR_SET);
                loadDlc   = `DLC_ONE;
                if (loadReady)
                    next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state          <= S_IDLE;
            pending        <= 1'b0;
            snapIn         <= 8'h00;
            inLast         <= 8'h00;
            outputChannels <= 8'h00;
        end else begin
            state <= next_state;
            if (setCmd)
                outputChannels <= rxData[63:56]; // R6 R14
            // Change seen while busy stays pending, so the latest input state is still sent
            if (inChange) begin
                inLast  <= inSync;
                pending <= 1'b1;
            end
            // Replies start only when idle; a command arriving mid-reply gets no answer, though a set still updates the outputs
            if (state == S_IDLE) begin
                if (setCmd) begin
                    state <= S_OUTACK; // R14
                end else if (typeQry) begin
                    state <= S_TYPEACK;
                end else if (confQry) begin
                    state <= pairMode ? S_IDLE : S_CONFACK; // R9
                end else if ((pending || inChange) && isInputSide) begin
                    snapIn  <= inChange ? inSync : inLast;
                    pending <= 1'b0;
                    state   <= S_PAIRSET; // R12
                end else if (pending || inChange) begin
                    snapIn  <= inChange ? inSync : inLast;
                    pending <= 1'b0;
                    state   <= S_REPORT; // R13
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outgoing frame register
    // One frame deep, so a reply queued behind a report waits for the bus

    frame_slot u_slot (
        .clk       (clk),
        .rst_n     (rst_n),
        .loadValid (loadValid),
        .loadId    (loadId),
        .loadDlc   (loadDlc),
        .loadData  (loadData),
        .loadReady (loadReady),
        .txValid   (txValid),
        .txId      (txId),
        .txDlc     (txDlc),
        .txData    (txData),
        .txReady   (txReady)
    );

endmodule

// File: tb/can_ctrl_model.sv
// Behavioural CAN controller beside the node
// Bench sets stall, sends frames and pops the captured queues
`timescale 1ns/1ps
module can_ctrl_model (
    input  wire        clk,
    input  wire        txValid,
    input  wire [28:0] txId,
    input  wire [3:0]  txDlc,
    input  wire [63:0] txData,
    output reg         txReady,
    output reg         rxStrobe,
    output reg  [28:0] rxId,
    output reg         rxRtr,
    output reg  [3:0]  rxDlc,
    output reg  [63:0] rxData
);
int          stall = 0;
int          waited = 0;
logic [28:0] qId[$];
logic [3:0]  qDlc[$];
logic [63:0] qData[$];
initial begin
    {txReady, rxStrobe, rxId, rxRtr, rxDlc, rxData} = '0;
end
////////////////////////////////////////
// Every frame is taken, master or not
always @(posedge clk) begin
    if (txValid && txReady) begin
        qId.push_back(txId);
        qDlc.push_back(txDlc);
        qData.push_back(txData);
    end
    #1;
    if (txReady || !txValid) begin
        txReady = 0;
        waited = 0;
    end else if (waited >= stall)
        txReady = 1;
    else
        waited++;
end
// Idle id and data lines show inverted junk, not a stale frame
task automatic send(input logic [28:0] id, input logic rtr, input logic [3:0] dlc,
                    input logic [63:0] d);
    @(posedge clk);
    #1;
    {rxStrobe, rxRtr, rxId, rxDlc, rxData} = {1'b1, rtr, id, dlc, d};
    @(posedge clk);
    #1;
    {rxStrobe, rxId, rxData} = {1'b0, ~id, ~d};
endtask
endmodule

// File: tb/can_io_pair_connection_test.sv
// Self-checking bench: node 9 as input side of a pair at selector D,
// then node 10 at selector 7 outside pair mode after a second reset
// Controller model carries every frame in both directions
`timescale 1ns/1ps
module can_io_pair_connection_test;
logic        clk = 0;
logic        rst_n = 0;
logic [7:0]  inputs = 8'h00;
logic [3:0]  rateSel = 4'hD;
logic [6:0]  nodeSel = 7'h09;
logic [63:0] lastData;
wire  [7:0]  outputChannels;
wire         pairMode, fastRate, operational, heartbeatLost;
wire         rxStrobe, rxRtr, txValid, txReady;
wire  [28:0] rxId, txId;
wire  [3:0]  rxDlc, txDlc;
wire  [63:0] rxData, txData;
int          errors = 0;
int          n_checks = 0;
int          cycles = 0;
always #10 clk = ~clk;
// Short heartbeat limit keeps the quiet test brief
// Node roles come from the bench's own switch settings, never from a query
pair_io_node #(.HB_TIMEOUT_CYC(32'h00000064)) uut (.clk, .rst_n, .rateSwitch(rateSel),
    .nodeSwitch(nodeSel), .input_channels(inputs), .outputChannels, .pairMode, .fastRate,
    .operational, .heartbeatLost, .rxStrobe, .rxId, .rxRtr, .rxDlc, .rxData, .txValid,
    .txId, .txDlc, .txData, .txReady);
can_ctrl_model ctl (.clk, .txValid, .txId, .txDlc, .txData, .txReady, .rxStrobe, .rxId,
    .rxRtr, .rxDlc, .rxData);
////////////////////////////////////////
task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
        errors++;
        $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
endtask
task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
// Key is ack, function and node; flags are left to the checker
task frame(input logic [15:0] key, input logic [3:0] dlc, input logic [7:0] b0);
    int          k;
    logic [28:0] id;
    k = 0;
    while (ctl.qId.size() == 0 && k < 200) begin
        @(posedge clk);
        k++;
    end
    check("frame sent", 64'(ctl.qId.size() != 0), 64'h1);
    if (ctl.qId.size() != 0) begin
        id = ctl.qId.pop_front();
        lastData = ctl.qData.pop_front();
        check("frame id", 64'(id[23:8]), 64'(key));
        check("frame dlc", 64'(ctl.qDlc.pop_front()), 64'(dlc));
        check("frame byte0", 64'(lastData[63:56]), 64'(b0));
    end
endtask
////////////////////////////////////////
task t_start;
    int k;
    k = 0;
    while (operational !== 1'b1 && k < 50) begin
        @(posedge clk);
        k++;
    end
    check("pairMode", 64'(pairMode), 64'h1);
    check("fastRate", 64'(fastRate), 64'h1);
    check("operational", 64'(operational), 64'h1);
endtask
task t_input;
    ctl.stall = 3;
    @(posedge clk);
    #1;
    inputs = 8'h55;
    frame({1'b0, 8'h10, 7'h0A}, 4'h8, 8'h55);
    frame({1'b1, 8'h10, 7'h09}, 4'h1, 8'h55);
    ctl.stall = 0;
endtask
task t_set;
    ctl.send({6'h00, 8'h10, 7'h09, 8'h00}, 1'b0, 4'h8, 64'hAA00000000000000);
    frame({1'b1, 8'h10, 7'h09}, 4'h1, 8'hAA);
    check("outputs", 64'(outputChannels), 64'hAA);
endtask
task t_iotype;
    ctl.send({6'h00, 8'hF3, 7'h09, 8'h00}, 1'b1, 4'h6, 64'h0);
    frame({1'b1, 8'hF3, 7'h09}, 4'h6, 8'h08);
    check("type counts", 64'(lastData[63:16]), 64'h080800000000);
endtask
// Waits past the heartbeat limit so a live supervisor would trip
task t_quiet;
    ctl.send({6'h00, 8'h61, 7'h09, 8'h00}, 1'b1, 4'h1, 64'h0);
    ctl.send({6'h00, 8'h70, 7'h00, 8'h00}, 1'b0, 4'h0, 64'h0);
    repeat (150) @(posedge clk);
    check("conflict reply", 64'(ctl.qId.size()), 64'h0);
    check("heartbeatLost", 64'(heartbeatLost), 64'h0);
endtask
// Second reset: selector 7 and node 10, so a master start is needed
task t_nonpair;
    @(posedge clk);
    #1;
    rst_n = 0;
    rateSel = 4'h7;
    nodeSel = 7'h0A;
    inputs = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1;
    repeat (10) @(posedge clk);
    check("self start", 64'(operational), 64'h0);
    check("pairMode below 8", 64'(pairMode), 64'h0);
    check("fastRate off", 64'(fastRate), 64'h0);
    ctl.send({6'h00, 8'h01, 7'h0A, 8'h00}, 1'b0, 4'h0, 64'h0);
    ctl.send({6'h00, 8'h61, 7'h0A, 8'h00}, 1'b1, 4'h1, 64'h0);
    frame({1'b1, 8'h61, 7'h0A}, 4'h1, 8'h00);
    @(posedge clk);
    #1;
    inputs = 8'h03;
    frame({1'b1, 8'h10, 7'h0A}, 4'h1, 8'h03);
    repeat (120) @(posedge clk);
    check("heartbeat limit", 64'(heartbeatLost), 64'h1);
    check("no pair frame", 64'(ctl.qId.size()), 64'h0);
    ctl.send({6'h00, 8'h70, 7'h00, 8'h00}, 1'b0, 4'h0, 64'h0);
    check("heartbeat seen", 64'(heartbeatLost), 64'h0);
endtask
initial begin
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1;
    t_start;
    t_input;
    t_set;
    t_iotype;
    t_quiet;
    t_nonpair;
    give_verdict;
end
always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
        errors++;
        give_verdict;
    end
end
endmodule

// File: tb/pair_io_checker.sv
// Port assertions for the pair I/O node
// Bound into every pair_io_node; switches held stable from reset
`timescale 1ns/1ps
module pair_io_checker (
    input wire        clk,
    input wire        rst_n,
    input wire [3:0]  rateSwitch,
    input wire [6:0]  nodeSwitch,
    input wire [7:0]  outputChannels,
    input wire        pairMode,
    input wire        fastRate,
    input wire        operational,
    input wire        heartbeatLost,
    input wire        rxStrobe,
    input wire [28:0] rxId,
    input wire        rxRtr,
    input wire [63:0] rxData,
    input wire        txValid,
    input wire [28:0] txId,
    input wire [3:0]  txDlc,
    input wire [63:0] txData,
    input wire        txReady
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
// Replies only promised with a free slot
wire       toMe = rxStrobe && operational && !rxId[23] && rxId[14:8] == nodeSwitch && !txValid;
wire       setCmd = toMe && rxId[22:15] == 8'h10 && !rxRtr;
wire       typeCmd = toMe && rxId[22:15] == 8'hF3 && rxRtr;
wire       conflictQ = pairMode && rxStrobe && rxId[22:15] == 8'h61 && !txValid;
wire [7:0] rxByte = rxData[63:56];
////////////////////////////////////////
chk_pair_range: assert property (pairMode |-> rateSwitch >= 4'h8)
    else $error("pair mode outside 8 to F");
chk_fast_sel: assert property (fastRate |-> rateSwitch == 4'hD)
    else $error("fast rate without D");
chk_self_start: assert property ($rose(pairMode) |=> operational)
    else $error("not operational after pair mode");
chk_hb_quiet: assert property (pairMode |-> !heartbeatLost)
    else $error("heartbeat lost in pair mode");
chk_conflict_mute: assert property (conflictQ |=> !txValid [*4])
    else $error("conflict answered in pair mode");
chk_set_apply: assert property (setCmd |=> outputChannels == $past(rxByte))
    else $error("outputs not set");
chk_set_reply: assert property (setCmd |-> ##2 txValid && txDlc == 4'h1
    && txId[23:8] == {1'b1, 8'h10, nodeSwitch} && txData[63:56] == $past(rxByte, 2))
    else $error("bad set reply");
chk_type_reply: assert property (typeCmd |-> ##2 txValid && txDlc == 4'h6
    && txId[23:15] == {1'b1, 8'hF3} && txData[63:16] == 48'h080800000000)
    else $error("bad type reply");
chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txId))
    else $error("frame dropped before accept");
chk_pair_dest: assert property (txValid && !txId[23] && txId[7:0] == 8'h01
    |-> txId[14:8] == nodeSwitch + 7'h01 && txDlc == 4'h8)
    else $error("pair frame to wrong node");
chk_report_id: assert property (txValid && txId[7:0] == 8'h02
    |-> txId[14:8] == nodeSwitch && txDlc == 4'h1)
    else $error("bad input report");
cover property (setCmd);
cover property (typeCmd);
cover property (txValid && txReady && txId[7:0] == 8'h02);
cover property (txValid && txReady && txId[22:15] == 8'h61);
endmodule
bind pair_io_node pair_io_checker chk (.clk, .rst_n, .rateSwitch, .nodeSwitch, .outputChannels,
    .pairMode, .fastRate, .operational, .heartbeatLost, .rxStrobe, .rxId, .rxRtr, .rxData,
    .txValid, .txId, .txDlc, .txData, .txReady);
